// File: rtl/scsp_pkg.sv
// package: constants and types shared by both ends of the config port
package scsp_pkg;
  // three-wire frame layout, counted in link clock rising edges
  localparam logic [5:0] W3_ADDR_BITS  = 6'h0F; // address bits before dir
  localparam logic [5:0] W3_HDR_BITS   = 6'h10; // address plus direction
  localparam logic [5:0] W3_FRAME_BITS = 6'h20; // whole frame
  localparam int         W3_DATA_BITS  = 16;    // register data width
  // i2c byte handling
  localparam logic [3:0] I2C_ACK_SLOT  = 4'h8;  // bits before the ack slot
  localparam logic [2:0] I2C_ENC_BYTES = 3'h4;  // addr hi, lo, data hi, lo
  localparam logic [6:0] I2C_TGT_BASE  = 7'h3C; // target with both straps low
  // three-wire link clock half period, i2c quarter bit, in clk_sys cycles; slower than the clk/8 limit
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
  // value of every synchroniser stage after reset
  localparam logic [5:0] PIN_RST       = 6'h00;

  // device side i2c receiver states
  typedef enum logic [2:0] {
    I_IDLE    = 3'b000,
    I_DEVADDR = 3'b001,
    I_RX      = 3'b010,
    I_ACK     = 3'b011,
    I_TX      = 3'b100,
    I_TXACK   = 3'b101
  } scsp_i2c_st_t;

  // host side sequencer states
  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_W3     = 2'b01,
    H_W3_END = 2'b10,
    H_I2C    = 2'b11
  } scsp_host_st_t;

  // kinds of step in a host i2c sequence
  typedef enum logic [2:0] {
    K_START   = 3'b000,
    K_TX      = 3'b001,
    K_RX_ACK  = 3'b010,
    K_RX_NACK = 3'b011,
    K_STOP    = 3'b100
  } scsp_step_t;
endpackage : scsp_pkg

// File: rtl/scsp_link_if.sv
// interface: the shared clock, select and data wires between host and sensor
`timescale 1ns/1ps
interface scsp_link_if;
  logic serialClk;        // link clock, made by the host
  logic serialSelectLine; // three-wire select, active high
  logic hostLineOut;      // host data level when enabled
  logic hostLineOe;       // host drives the data line
  logic devLineOut;       // device data level when enabled
  logic devLineOe;        // device drives the data line
  logic bidirSerialLine;  // resolved data wire

  // wired-and with pull-up: push-pull in three-wire, open drain in i2c
  assign bidirSerialLine = (~hostLineOe | hostLineOut) &
                           (~devLineOe | devLineOut);

  modport host (
    output serialClk,
    output serialSelectLine,
    output hostLineOut,
    output hostLineOe,
    input  bidirSerialLine
  );

  modport device (
    input  serialClk,
    input  serialSelectLine,
    input  bidirSerialLine,
    output devLineOut,
    output devLineOe
  );
endinterface : scsp_link_if

// File: rtl/scsp_host.sv
// module: host end, issues register reads and writes over either protocol
`timescale 1ns/1ps
module scsp_host
  import scsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  scsp_link_if.host        link,
  input  wire logic        useI2c,
  input  wire logic [6:0]  targetAddr,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic        cmdWrite,
  input  wire logic [15:0] cmdAddr,
  input  wire logic [15:0] cmdData,
  output logic             respValid,
  output logic [15:0]      respData,
  output logic             respNack
);
  scsp_host_st_t hSt_r;      // sequencer state
  logic [3:0]    divCnt_r;   // link clock divider
  logic          tick;       // one half period (or quarter bit) elapsed
  logic          sclk_r;     // link clock out
  logic          sel_r;      // select out
  logic          lineOut_r;  // data level out
  logic          lineOe_r;   // data drive enable
  logic          lineMeta_r; // data line, first sync stage
  logic          lineSync_r; // data line, safe to read
  logic [31:0]   frame_r;    // three-wire frame, msb is on the line
  logic [5:0]    bitCnt_r;   // bits done in frame or byte
  logic [1:0]    qCnt_r;     // quarter of an i2c bit
  logic [3:0]    step_r;     // i2c sequence step
  logic          isWrite_r;  // command is a write
  logic [15:0]   addr_r;     // held register address
  logic [15:0]   data_r;     // held write data
  logic [6:0]    tgt_r;      // held i2c target
  logic [15:0]   rx_r;       // read data shifted in
  logic          nack_r;     // any byte sent went unacknowledged
  scsp_step_t    curKind;    // kind of current i2c step
  logic [7:0]    curByte;    // byte sent by current step

  assign tick = (divCnt_r == SCLK_HALF_CYC - 4'h1);

  // divider: the host makes the link clock, so it is no second domain
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      divCnt_r <= 4'h0;
    end else if (clkEn) begin
      divCnt_r <= (hSt_r == H_IDLE || tick) ? 4'h0 : divCnt_r + 4'h1;
    end
  end

  // data line comes back from the device, two stages before use
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lineMeta_r <= 1'b0;
      lineSync_r <= 1'b0;
    end else if (clkEn) begin
      lineMeta_r <= link.bidirSerialLine;
      lineSync_r <= lineMeta_r;
    end
  end

  // i2c program: write S,W,AH,AL,DH,DL,P; read S,W,AH,AL,Sr,R,D,D,P
  always_comb begin
    curKind = K_STOP;
    curByte = 8'h00;
    case (step_r)
      4'h0: curKind = K_START;
      4'h1: begin
        curKind = K_TX;
        curByte = {tgt_r, 1'b0};
      end
      4'h2: begin
        curKind = K_TX;
        curByte = addr_r[15:8];
      end
      4'h3: begin
        curKind = K_TX;
        curByte = addr_r[7:0];
      end
      4'h4: begin
        curKind = isWrite_r ? K_TX : K_START;
        curByte = data_r[15:8];
      end
      4'h5: begin
        curKind = K_TX;
        curByte = isWrite_r ? data_r[7:0] : {tgt_r, 1'b1};
      end
      4'h6: curKind = isWrite_r ? K_STOP : K_RX_ACK;
      4'h7: curKind = K_RX_NACK;
      default: curKind = K_STOP;
    endcase
  end

  // sequencer: one concern, the wire activity of one command
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hSt_r     <= H_IDLE;
      sclk_r    <= 1'b0;
      sel_r     <= 1'b0;
      lineOut_r <= 1'b1;
      lineOe_r  <= 1'b0;
      frame_r   <= 32'h00000000;
      bitCnt_r  <= 6'h00;
      qCnt_r    <= 2'h0;
      step_r    <= 4'h0;
      isWrite_r <= 1'b0;
      addr_r    <= 16'h0000;
      data_r    <= 16'h0000;
      tgt_r     <= 7'h00;
      rx_r      <= 16'h0000;
      nack_r    <= 1'b0;
      cmdReady  <= 1'b1;
      respValid <= 1'b0;
      respData  <= 16'h0000;
      respNack  <= 1'b0;
    end else if (clkEn) begin
      respValid <= 1'b0;
      case (hSt_r)
        H_IDLE: begin
          sclk_r <= useI2c; // i2c idles high, three-wire idles low
          if (cmdValid && cmdReady) begin
            cmdReady  <= 1'b0;
            isWrite_r <= cmdWrite;
            addr_r    <= cmdAddr;
            data_r    <= cmdData;
            tgt_r     <= targetAddr;
            nack_r    <= 1'b0;
            step_r    <= 4'h0;
            qCnt_r    <= 2'h0;
            bitCnt_r  <= 6'h00;
            if (useI2c) begin
              hSt_r <= H_I2C;
            end else begin
              hSt_r     <= H_W3;
              sel_r     <= 1'b1;
              sclk_r    <= 1'b0;
              lineOe_r  <= 1'b1;
              lineOut_r <= cmdAddr[14];
              frame_r   <= {cmdAddr[14:0], ~cmdWrite, cmdData};
            end
          end
        end
        H_W3: begin
          if (tick) begin
            if (!sclk_r) begin
              sclk_r <= 1'b1; // device samples here
            end else begin
              sclk_r <= 1'b0;
              if (bitCnt_r >= W3_HDR_BITS && !isWrite_r) begin
                rx_r <= {rx_r[14:0], lineSync_r};
              end
              if (bitCnt_r == W3_FRAME_BITS - 6'h01) begin
                hSt_r <= H_W3_END;
              end else begin
                bitCnt_r  <= bitCnt_r + 6'h01;
                frame_r   <= {frame_r[30:0], 1'b0};
                lineOut_r <= frame_r[30];
                lineOe_r  <= isWrite_r || bitCnt_r < W3_ADDR_BITS;
              end
            end
          end
        end
        H_W3_END: begin
          if (tick) begin
            sel_r     <= 1'b0;
            lineOe_r  <= 1'b0;
            respValid <= 1'b1;
            respData  <= rx_r;
            respNack  <= 1'b0;
            cmdReady  <= 1'b1;
            hSt_r     <= H_IDLE;
          end
        end
        H_I2C: begin
          if (tick) begin
            qCnt_r <= qCnt_r + 2'h1;
            // clock low first so data bits never move while the clock is high
            case (qCnt_r)
              2'h0: sclk_r <= 1'b0;
              2'h1: begin
                lineOut_r <= 1'b0;
                if (curKind == K_STOP) begin
                  lineOe_r <= 1'b1;
                end else if (curKind == K_TX) begin
                  lineOe_r <= (bitCnt_r[3:0] != I2C_ACK_SLOT) &&
                              !curByte[~bitCnt_r[2:0]];
                end else if (curKind == K_START) begin
                  lineOe_r <= 1'b0;
                end else begin
                  lineOe_r <= (bitCnt_r[3:0] == I2C_ACK_SLOT) &&
                              (curKind == K_RX_ACK);
                end
              end
              2'h2: sclk_r <= 1'b1;
              default: begin
                if (curKind == K_START) begin
                  lineOe_r <= 1'b1; // data falls with clock high
                end else if (curKind == K_STOP) begin
                  lineOe_r <= 1'b0; // data rises with clock high
                end else if (bitCnt_r[3:0] == I2C_ACK_SLOT) begin
                  if (curKind == K_TX) begin
                    nack_r <= nack_r | lineSync_r;
                  end
                end else if (curKind != K_TX) begin
                  rx_r <= {rx_r[14:0], lineSync_r};
                end
                if ((curKind == K_TX || curKind == K_RX_ACK ||
                     curKind == K_RX_NACK) &&
                    bitCnt_r[3:0] != I2C_ACK_SLOT) begin
                  bitCnt_r <= bitCnt_r + 6'h01;
                end else begin
                  bitCnt_r <= 6'h00;
                  step_r   <= step_r + 4'h1;
                  if (curKind == K_STOP) begin
                    respValid <= 1'b1;
                    respData  <= rx_r;
                    respNack  <= nack_r;
                    cmdReady  <= 1'b1;
                    hSt_r     <= H_IDLE;
                  end
                end
              end
            endcase
          end
        end
        default: hSt_r <= H_IDLE;
      endcase
    end
  end

  assign link.serialClk        = sclk_r;
  assign link.serialSelectLine = sel_r;
  assign link.hostLineOut      = lineOut_r;
  assign link.hostLineOe       = lineOe_r;
endmodule : scsp_host

// File: rtl/scsp_device.sv
// module: sensor end of the config port, three-wire and i2c decoders
`timescale 1ns/1ps
module scsp_device
  import scsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  scsp_link_if.device      link,
  input  wire logic        protoSelI2c,
  input  wire logic        targetAddrStrapLsb,
  input  wire logic        targetAddrStrapMsb,
  output logic             regWrStb,
  output logic             regRdStb,
  output logic [15:0]      regAddr,
  output logic [15:0]      regWrData,
  input  wire logic [15:0] regRdData
);
  logic [5:0]   pinMeta_r;  // first stage, read only by the second
  logic [5:0]   pinSync_r;  // synchronised pins
  logic [2:0]   pinPrev_r;  // previous clock, data, select
  logic         clkS;       // link clock
  logic         datS;       // data line
  logic         selS;       // select line
  logic         i2cMode;    // protocol strap
  logic         clkRise;    // link clock rising edge seen
  logic         clkFall;    // link clock falling edge seen
  logic         selFall;    // select dropped
  logic         i2cStart;   // start or repeated start
  logic         i2cStop;    // stop condition
  logic [6:0]   tgtAddr;    // own i2c target
  logic [5:0]   w3Cnt_r;    // rising edges in this frame
  logic [15:0]  w3Hdr_r;    // address and direction
  logic [15:0]  w3Data_r;   // write data shifted in
  logic         w3WrReq;    // complete write frame ended
  logic         w3RdReq;    // direction one arriving
  scsp_i2c_st_t iSt_r;      // i2c state
  logic [3:0]   iBits_r;    // bits seen in current byte
  logic [7:0]   iShift_r;   // received byte
  logic [2:0]   iByte_r;    // bytes since target, or bytes sent
  logic         iRead_r;    // target came with read bit
  logic         iAckOk_r;   // host acked our byte
  logic [15:0]  iAddr_r;    // register address from i2c
  logic [7:0]   iDataHi_r;  // upper write byte
  logic         iWrReq;     // second data byte complete
  logic         iRdReq;     // read target matched
  logic         rdLoad_r;   // register data valid this cycle
  logic [15:0]  txShift_r;  // read data, msb next out
  logic         lineOut_r;  // data level out
  logic         lineOe_r;   // data drive enable

  // two stages on every pin before use
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pinMeta_r <= PIN_RST;
      pinSync_r <= PIN_RST;
      pinPrev_r <= PIN_RST[2:0];
    end else if (clkEn) begin
      pinMeta_r <= {protoSelI2c, targetAddrStrapMsb, targetAddrStrapLsb,
                    link.serialSelectLine, link.bidirSerialLine,
                    link.serialClk};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r[2:0];
    end
  end

  assign clkS     = pinSync_r[0];
  assign datS     = pinSync_r[1];
  assign selS     = pinSync_r[2];
  assign i2cMode  = pinSync_r[5];
  assign clkRise  = clkS & ~pinPrev_r[0];
  assign clkFall  = ~clkS & pinPrev_r[0];
  assign selFall  = ~selS & pinPrev_r[2];
  // clock and data share sync depth, so their order is kept
  assign i2cStart = i2cMode & clkS & pinPrev_r[0] & pinPrev_r[1] & ~datS;
  assign i2cStop  = i2cMode & clkS & pinPrev_r[0] & ~pinPrev_r[1] & datS;
  assign tgtAddr  = I2C_TGT_BASE + {5'h00, pinSync_r[4:3]};

  // three-wire shifter; count saturates, extra edges are ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      w3Cnt_r  <= 6'h00;
      w3Hdr_r  <= 16'h0000;
      w3Data_r <= 16'h0000;
    end else if (clkEn) begin
      if (i2cMode || !selS) begin
        w3Cnt_r <= 6'h00;
      end else if (clkRise && w3Cnt_r != W3_FRAME_BITS) begin
        w3Cnt_r <= w3Cnt_r + 6'h01;
        if (w3Cnt_r < W3_HDR_BITS) begin
          w3Hdr_r <= {w3Hdr_r[14:0], datS};
        end else begin
          w3Data_r <= {w3Data_r[14:0], datS};
        end
      end
    end
  end

  // a write lands only when select drops after a full frame
  assign w3WrReq = !i2cMode && selFall && w3Cnt_r == W3_FRAME_BITS &&
                   !w3Hdr_r[0];
  // fetch early: the first read bit goes out on the next rise
  assign w3RdReq = !i2cMode && selS && clkRise && datS &&
                   w3Cnt_r == W3_ADDR_BITS;
  assign iWrReq  = iSt_r == I_RX && clkFall && iBits_r == I2C_ACK_SLOT &&
                   iByte_r == I2C_ENC_BYTES - 3'h1;
  assign iRdReq  = iSt_r == I_DEVADDR && clkFall &&
                   iBits_r == I2C_ACK_SLOT && iShift_r == {tgtAddr, 1'b1};

  // i2c receiver: bits counted on rises, decisions on falls
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      iSt_r     <= I_IDLE;
      iBits_r   <= 4'h0;
      iShift_r  <= 8'h00;
      iByte_r   <= 3'h0;
      iRead_r   <= 1'b0;
      iAckOk_r  <= 1'b0;
      iAddr_r   <= 16'h0000;
      iDataHi_r <= 8'h00;
    end else if (clkEn) begin
      if (!i2cMode) begin
        iSt_r <= I_IDLE;
      end else if (i2cStart) begin
        iSt_r   <= I_DEVADDR; // address kept across a repeated start
        iBits_r <= 4'h0;
        iByte_r <= 3'h0;
      end else if (i2cStop) begin
        iSt_r <= I_IDLE;
      end else if (clkRise) begin
        if (iSt_r == I_TXACK) begin
          iAckOk_r <= ~datS;
        end else if (iBits_r != I2C_ACK_SLOT) begin
          iBits_r  <= iBits_r + 4'h1;
          iShift_r <= {iShift_r[6:0], datS};
        end
      end else if (clkFall) begin
        case (iSt_r)
          I_DEVADDR: begin
            if (iBits_r == I2C_ACK_SLOT) begin
              iRead_r <= iShift_r[0];
              iSt_r   <= (iShift_r[7:1] == tgtAddr) ? I_ACK : I_IDLE;
            end
          end
          I_RX: begin
            if (iBits_r == I2C_ACK_SLOT) begin
              case (iByte_r)
                3'h0: iAddr_r[15:8] <= iShift_r;
                3'h1: iAddr_r[7:0]  <= iShift_r;
                3'h2: iDataHi_r     <= iShift_r;
                default: ;
              endcase
              // a fifth byte would run past the four-byte access: refused
              iSt_r   <= (iByte_r < I2C_ENC_BYTES) ? I_ACK : I_IDLE;
              iByte_r <= iByte_r + 3'h1;
            end
          end
          I_ACK: begin
            iBits_r <= 4'h0;
            iSt_r   <= iRead_r ? I_TX : I_RX;
            if (iRead_r) begin
              iByte_r <= 3'h0;
            end
          end
          I_TX: begin
            if (iBits_r == I2C_ACK_SLOT) begin
              iSt_r <= I_TXACK;
            end
          end
          I_TXACK: begin
            iBits_r <= 4'h0;
            iByte_r <= 3'h1;
            iSt_r   <= (iAckOk_r && iByte_r == 3'h0) ? I_TX : I_IDLE;
          end
          default: iSt_r <= I_IDLE;
        endcase
      end
    end
  end

  // register port: one strobe per accepted access, address held after
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      regWrStb  <= 1'b0;
      regRdStb  <= 1'b0;
      regAddr   <= 16'h0000;
      regWrData <= 16'h0000;
      rdLoad_r  <= 1'b0;
    end else if (clkEn) begin
      regWrStb <= w3WrReq | iWrReq;
      regRdStb <= w3RdReq | iRdReq;
      rdLoad_r <= regRdStb;
      if (w3WrReq) begin
        regAddr   <= {1'b0, w3Hdr_r[15:1]};
        regWrData <= w3Data_r;
      end else if (w3RdReq) begin
        regAddr <= {1'b0, w3Hdr_r[14:0]};
      end else if (iWrReq) begin
        regAddr   <= iAddr_r;
        regWrData <= {iDataHi_r, iShift_r};
      end else if (iRdReq) begin
        regAddr <= iAddr_r;
      end
    end
  end

  // data line driver: push-pull in three-wire, pull-low only in i2c
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lineOut_r <= 1'b0;
      lineOe_r  <= 1'b0;
      txShift_r <= 16'h0000;
    end else if (clkEn) begin
      if (rdLoad_r) begin
        txShift_r <= regRdData;
      end
      if (!i2cMode) begin
        if (!selS) begin
          lineOe_r <= 1'b0;
        end else if (clkRise && w3Hdr_r[0] && w3Cnt_r >= W3_HDR_BITS &&
                     w3Cnt_r != W3_FRAME_BITS) begin
          lineOe_r  <= 1'b1;
          lineOut_r <= txShift_r[15];
          txShift_r <= {txShift_r[14:0], 1'b0};
        end
      end else if (i2cStart || i2cStop) begin
        lineOe_r <= 1'b0;
      end else if (clkFall) begin
        lineOut_r <= 1'b0;
        lineOe_r  <= 1'b0; // release unless a case below pulls low
        case (iSt_r)
          I_DEVADDR: begin
            if (iBits_r == I2C_ACK_SLOT && iShift_r[7:1] == tgtAddr) begin
              lineOe_r <= 1'b1;
            end
          end
          I_RX: begin
            if (iBits_r == I2C_ACK_SLOT && iByte_r < I2C_ENC_BYTES) begin
              lineOe_r <= 1'b1;
            end
          end
          I_ACK: begin
            if (iRead_r) begin
              lineOe_r  <= ~txShift_r[15];
              txShift_r <= {txShift_r[14:0], 1'b0};
            end
          end
          I_TX: begin
            if (iBits_r != I2C_ACK_SLOT) begin
              lineOe_r  <= ~txShift_r[15];
              txShift_r <= {txShift_r[14:0], 1'b0};
            end
          end
          I_TXACK: begin
            if (iAckOk_r && iByte_r == 3'h0) begin
              lineOe_r  <= ~txShift_r[15];
              txShift_r <= {txShift_r[14:0], 1'b0};
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign link.devLineOut = lineOut_r;
  assign link.devLineOe  = lineOe_r;
endmodule : scsp_device

// File: dv/scsp_link_sva.sv
// checker: timing of the wires between host and sensor ends
`timescale 1ns/1ps
module scsp_link_sva import scsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic serialClk,
  input wire logic serialSelectLine,
  input wire logic hostLineOe,
  input wire logic hostLineOut,
  input wire logic devLineOut,
  input wire logic devLineOe
);
  wire        sel = serialSelectLine; // three-wire frame in progress
  logic [5:0] rise_r;                 // clock rises in this frame
  // select low clears the count, so a cut frame never carries over
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !sel) rise_r <= 6'h00;
    else if ($rose(serialClk)) rise_r <= rise_r + 6'h01;
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_LEN: assert property ($fell(sel) |-> rise_r == W3_FRAME_BITS)
    else $error("frame length");
  AST_SEL: assert property ($rose(sel) |-> !serialClk)
    else $error("select rose on high clock");
  AST_HREL: assert property ($fell(sel) |-> !hostLineOe)
    else $error("host kept the line");
  AST_HCHG: assert property (sel && $changed(hostLineOut) |->
    !serialClk) else $error("host bit moved on high clock");
  AST_DCHG: assert property (sel && devLineOe && $changed(devLineOut)
    |-> serialClk) else $error("device bit on low clock");
  AST_RD: assert property (sel && $rose(devLineOe) |->
    serialClk && rise_r == W3_HDR_BITS + 6'h01) else $error("read start");
  AST_FIGHT: assert property (sel && hostLineOe |-> !devLineOe)
    else $error("both ends drive");
  AST_REL: assert property ($fell(sel) |-> ##[2:6] !devLineOe)
    else $error("device kept the line");
  AST_ACK: assert property (!sel && $rose(devLineOe) |-> !serialClk)
    else $error("ack on high clock");
  cover property (sel && $rose(devLineOe));
  cover property (!sel && $rose(devLineOe));
  cover property ($fell(sel));
endmodule : scsp_link_sva

// File: dv/tb_sensor_config_serial_port.sv
// bench: host and sensor ends joined over the link
`timescale 1ns/1ps
module tb_sensor_config_serial_port import scsp_pkg::*;;
  bit          clk_sys, rst_b, hostRst_b, useI2c, protoI2c; // zero at start
  bit          strapLsb, strapMsb, cmdValid, cmdWrite;
  bit   [6:0]  targetAddr = I2C_TGT_BASE;
  bit   [15:0] cmdAddr, cmdData, regRdData; // regRdData: register model
  logic [15:0] wrAddr = 16'h0000, wrData = 16'h0000; // last write seen
  logic [15:0] respData, regAddr, regWrData;
  logic        cmdReady, respValid, respNack, regWrStb, regRdStb;
  int          wrCount = 0, miscompares = 0, total_checks = 0;
  scsp_link_if link();
  scsp_host scsp_host_inst (.clk_sys, .rst_b(hostRst_b), .clkEn(1'b1), .link,
    .useI2c, .targetAddr, .cmdValid, .cmdReady, .cmdWrite, .cmdAddr,
    .cmdData, .respValid, .respData, .respNack);
  scsp_device scsp_device_inst (.clk_sys, .rst_b, .clkEn(1'b1), .link,
    .protoSelI2c(protoI2c), .targetAddrStrapLsb(strapLsb),
    .targetAddrStrapMsb(strapMsb), .regWrStb, .regRdStb, .regAddr,
    .regWrData, .regRdData);
  scsp_link_sva scsp_link_sva_inst (.clk_sys, .rst_b(rst_b & hostRst_b),
    .serialClk(link.serialClk), .serialSelectLine(link.serialSelectLine),
    .hostLineOe(link.hostLineOe), .devLineOut(link.devLineOut),
    .hostLineOut(link.hostLineOut),
    .devLineOe(link.devLineOe));
  always #5 clk_sys = ~clk_sys;
  // register model: a read returns the inverted address
  always @(posedge clk_sys) if (regRdStb === 1'b1) regRdData <= ~regAddr;
  // log each register write the device makes
  always @(posedge clk_sys) if (regWrStb === 1'b1) begin
    wrCount <= wrCount + 1;
    wrAddr <= regAddr;
    wrData <= regWrData;
  end
  task automatic chk(string what, logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) miscompares++;
    if (seen !== exp) $display("BAD %s exp %h seen %h", what, exp, seen);
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // one command; host reset after cut cycles if no answer, to drop select
  task automatic op(logic i2c, wr, logic [15:0] a, d, int cut);
    int n;
    useI2c = i2c;
    repeat (8) @(negedge clk_sys);
    {cmdWrite, cmdAddr, cmdData, cmdValid} = {wr, a, d, 1'b1};
    @(negedge clk_sys);
    cmdValid = 1'b0;
    for (n = 0; n < cut && respValid !== 1'b1; n++) @(negedge clk_sys);
    if (n == 4000) miscompares++;
    if (n == 4000) results();
    hostRst_b = n < cut;
    repeat (8) @(negedge clk_sys);
    hostRst_b = 1'b1;
  endtask : op
  // three-wire write, read, wrong strap and a frame cut short
  task automatic threeWire();
    int c = wrCount;
    op(1'b0, 1'b1, 16'hF1E7, 16'hD2B4, 4000);
    chk("w3 addr", wrAddr, 16'h71E7);
    chk("w3 data", wrData, 16'hD2B4);
    op(1'b0, 1'b0, 16'h0A53, 16'h0000, 4000);
    chk("w3 read", respData, 16'hF5AC);
    protoI2c = 1'b1;
    op(1'b0, 1'b1, 16'h1234, 16'h5678, 4000);
    chk("w3 strap", 16'(wrCount - c), 16'h0001);
    protoI2c = 1'b0;
    op(1'b0, 1'b1, 16'h1234, 16'h5678, 300);
    chk("w3 cut", 16'(wrCount - c), 16'h0001);
    op(1'b1, 1'b1, 16'h1234, 16'h5678, 4000);
    chk("w3 unselected", 16'(wrCount - c), 16'h0001);
    chk("w3 no ack", 16'(respNack), 16'h0001);
  endtask : threeWire
  // every strap setting: write, read back, then a foreign target
  task automatic i2cStraps();
    logic [15:0] a;
    protoI2c = 1'b1;
    for (int s = 0; s < 4; s++) begin
      {strapMsb, strapLsb} = 2'(s);
      targetAddr = I2C_TGT_BASE + 7'(s);
      a = 16'hC35A ^ 16'(s << 12);
      op(1'b1, 1'b1, a, ~a, 4000);
      chk("i2c nack", 16'(respNack), 16'h0000);
      chk("i2c addr", wrAddr, a);
      chk("i2c data", wrData, ~a);
      op(1'b1, 1'b0, a, 16'h0000, 4000);
      chk("i2c read", respData, ~a);
    end
    targetAddr = I2C_TGT_BASE;
    op(1'b1, 1'b1, 16'h0000, 16'h0000, 4000);
    chk("i2c foreign", 16'(respNack), 16'h0001);
    chk("i2c kept", wrAddr, 16'hF35A);
  endtask : i2cStraps
  initial begin
    repeat (3) @(negedge clk_sys);
    {rst_b, hostRst_b} = 2'b11;
    threeWire();
    i2cStraps();
    results();
  end
endmodule : tb_sensor_config_serial_port
